// *** rtl/wake_frame_cdr_config.sv ***
// Behaviour
// - High calibration byte read-only, resets zero
// - Low calibration byte read-only, resets zero
// - Filter codes give time constants 8/16/32
// - Adaptive: edges 1-3 bits apart use 32
// - Adaptive: edges 4-8 bits apart use 16
// - Adaptive: edges 9-10 bits apart use 8
// - Control byte enable bit; resets to 0x04
// - Reserved control bits ignore writes, read zero
// - Clock select picks 80/40/20/10 MHz recovery
// - Upper limit clamps recovered bit time; 0xa8
// - Lower limit clamps recovered bit time; 0x98
`timescale 1ns/1ps
`default_nettype none

module wake_frame_cdr_config
    import wake_cdr_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       soft_reset,
    // Serial register port pins
    input  wire logic       spi_sck,
    input  wire logic       spi_cs_n,
    input  wire logic       spi_mosi,
    output logic            spi_miso,
    output logic            spi_miso_oe,
    // Bus receive line
    input  wire logic       can_rxd,
    // Nominal bit time from the neighbouring bit-timing register
    input  wire logic [7:0] nominal_bit_time,
    // Recovery results
    output logic [7:0]      recovered_bit_time,
    output logic            recovery_locked
);
    import wake_cdr_pkg::*;

    // Synchronised pins
    logic       sck_s;
    logic       cs_n_s;
    logic       mosi_s;
    logic       rxd_s;
    logic       rxd_d_ff;

    // Register port
    logic [6:0] frame_addr;
    logic       frame_write;
    logic [7:0] frame_data;
    logic       frame_done;
    logic [7:0] rd_data;
    logic       miso_int;
    logic       miso_oe_int;
    logic       miso_ff;
    logic       miso_oe_ff;

    // Registers
    logic       clr;
    logic [7:0] cal_high_ff;
    logic [7:0] cal_low_ff;
    logic [7:0] ctrl_one_ff;
    logic [7:0] clk_sel_ff;
    logic [7:0] upper_lim_ff;
    logic [7:0] lower_lim_ff;
    logic       recovery_enable;
    logic [1:0] edge_filter_select;
    logic [1:0] recovery_clock_select;

    // Recovery core
    cdr_state_e           state_ff;
    logic [3:0]           tick_cnt_ff;
    logic [3:0]           tick_period;
    logic                 tick;
    logic [INTERVAL_W-1:0] interval_ff;
    logic [15:0]          bt_ff;
    logic                 fall_edge;
    logic [19:0]          span;
    logic [3:0]           span_bits;
    logic [19:0]          expected;
    logic signed [20:0]   err;
    logic signed [20:0]   bt_sum;
    logic [2:0]           shift;
    logic                 span_ok;
    logic [15:0]          bt_next;
    logic [7:0]           bt_out_ff;
    logic                 locked_ff;

    // Number of whole bit times in a span, rounded to nearest
    function automatic logic [3:0] bits_in_span(input logic [19:0] s, input logic [15:0] bt);
        logic [3:0]  n;
        logic [19:0] thr;
        n = '0;
        for (int k = 1; k <= SPAN_SEARCH; k++) begin
            thr = 20'(k) * {4'h0, bt} - {5'h00, bt[15:1]};
            if (s >= thr) begin
                n = 4'(k);
            end
        end
        return n;
    endfunction : bits_in_span

    // Register read decode; reserved bits come back zero
    function automatic logic [7:0] read_reg(input logic [6:0] a);
        logic [7:0] d;
        d = '0;
        case (a)
            OFS_CAL_HIGH:  d = cal_high_ff;
            OFS_CAL_LOW:   d = cal_low_ff;
            OFS_CTRL_ONE:  d = ctrl_one_ff & CTRL_ONE_MASK;
            OFS_CLK_SEL:   d = clk_sel_ff & CLK_SEL_MASK;
            OFS_UPPER_LIM: d = upper_lim_ff;
            OFS_LOWER_LIM: d = lower_lim_ff;
            default:       d = '0;
        endcase
        return d;
    endfunction : read_reg

    pin_sync #(
        .WIDTH (4),
        .INIT  (4'ha)
    ) u_pin_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in ({can_rxd, spi_mosi, spi_cs_n, spi_sck}),
        .sync_out ({rxd_s, mosi_s, cs_n_s, sck_s})
    );

    serial_frame_slave u_serial_frame_slave (
        .clk        (clk),
        .reset      (reset),
        .sck        (sck_s),
        .cs_n       (cs_n_s),
        .mosi       (mosi_s),
        .rd_data    (rd_data),
        .addr       (frame_addr),
        .write_req  (frame_write),
        .wr_data    (frame_data),
        .frame_done (frame_done),
        .miso       (miso_int),
        .miso_oe    (miso_oe_int)
    );

    assign clr     = reset | soft_reset;
    assign rd_data = read_reg(frame_addr);

    // Control register writes; reserved positions are masked off
    always_ff @(posedge clk) begin
        if (clr) begin
            ctrl_one_ff  <= RST_CTRL_ONE;
            clk_sel_ff   <= RST_CLK_SEL;
            upper_lim_ff <= RST_UPPER_LIM;
            lower_lim_ff <= RST_LOWER_LIM;
        end else if (frame_done && frame_write) begin
            case (frame_addr)
                OFS_CTRL_ONE:  ctrl_one_ff  <= frame_data & CTRL_ONE_MASK;
                OFS_CLK_SEL:   clk_sel_ff   <= frame_data & CLK_SEL_MASK;
                OFS_UPPER_LIM: upper_lim_ff <= frame_data;
                OFS_LOWER_LIM: lower_lim_ff <= frame_data;
                default:       ;
            endcase
        end
    end

    assign recovery_enable       = ctrl_one_ff[ENABLE_POS];
    assign edge_filter_select    = ctrl_one_ff[FILT_MSB:FILT_LSB];
    assign recovery_clock_select = clk_sel_ff[CLK_SEL_MSB:CLK_SEL_LSB];

    // Recovery clock period in system clocks for each selection
    always_comb begin
        case (recovery_clock_select)
            CLK_80M: tick_period = TICK_DIV_80M;
            CLK_40M: tick_period = TICK_DIV_40M;
            CLK_20M: tick_period = TICK_DIV_20M;
            default: tick_period = TICK_DIV_10M;
        endcase
    end

    // Divider producing the recovery clock enable
    always_ff @(posedge clk) begin
        if (clr || !recovery_enable || tick) begin
            tick_cnt_ff <= 4'h1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 4'h1;
        end
    end

    assign tick = tick_cnt_ff >= tick_period;

    // Falling edge of the bus line
    always_ff @(posedge clk) begin
        if (reset) begin
            rxd_d_ff <= 1'b1;
        end else begin
            rxd_d_ff <= rxd_s;
        end
    end

    assign fall_edge = rxd_d_ff & ~rxd_s;

    // Recovery sequence: off, waiting for a first edge, tracking
    always_ff @(posedge clk) begin
        if (clr) begin
            state_ff <= CDR_OFF;
        end else begin
            case (state_ff)
                CDR_OFF: begin
                    if (recovery_enable) state_ff <= CDR_SEEK;
                end
                CDR_SEEK: begin
                    if (!recovery_enable) state_ff <= CDR_OFF;
                    else if (fall_edge) state_ff <= CDR_TRACK;
                end
                CDR_TRACK: begin
                    if (!recovery_enable) state_ff <= CDR_OFF;
                    else if (interval_ff == INTERVAL_MAX) state_ff <= CDR_SEEK;
                end
                default: state_ff <= CDR_OFF;
            endcase
        end
    end

    // Recovery clock ticks between falling edges, saturating when idle
    always_ff @(posedge clk) begin
        if (clr || state_ff == CDR_OFF || fall_edge) begin
            interval_ff <= '0;
        end else if (tick && interval_ff != INTERVAL_MAX) begin
            interval_ff <= interval_ff + 12'h001;
        end
    end

    // Spacing in bit times and the error against the current estimate
    assign span      = {interval_ff, 8'h00};
    assign span_bits = bits_in_span(span, bt_ff);
    assign expected  = {16'h0000, span_bits} * {4'h0, bt_ff};
    assign err       = $signed({1'b0, span}) - $signed({1'b0, expected});
    assign span_ok   = span_bits >= SPAN_MIN && span_bits <= SPAN_MAX;

    // Filter time constant, fixed or chosen from the edge spacing
    always_comb begin
        case (edge_filter_select)
            FILT_TC8:  shift = SHIFT_TC8;
            FILT_TC16: shift = SHIFT_TC16;
            FILT_TC32: shift = SHIFT_TC32;
            default: begin
                if (span_bits <= ADAPT_TC32_MAX) shift = SHIFT_TC32;
                else if (span_bits <= ADAPT_TC16_MAX) shift = SHIFT_TC16;
                else shift = SHIFT_TC8;
            end
        endcase
    end

    // Filtered estimate, held between the two limit registers
    always_comb begin
        bt_sum = $signed({5'h00, bt_ff}) + (err >>> shift);
        if (bt_sum > $signed({5'h00, upper_lim_ff, 8'h00})) begin
            bt_next = {upper_lim_ff, 8'h00};
        end else if (bt_sum < $signed({5'h00, lower_lim_ff, 8'h00})) begin
            bt_next = {lower_lim_ff, 8'h00};
        end else begin
            bt_next = bt_sum[15:0];
        end
    end

    // Estimate starts at the nominal setting and moves on each good edge
    always_ff @(posedge clk) begin
        if (clr) begin
            bt_ff <= '0;
        end else if (state_ff == CDR_OFF) begin
            bt_ff <= {nominal_bit_time, 8'h00};
        end else if (state_ff == CDR_TRACK && fall_edge && span_ok) begin
            bt_ff <= bt_next;
        end
    end

    // Calibration bytes mirror each new estimate; writes never reach them
    always_ff @(posedge clk) begin
        if (clr) begin
            cal_high_ff <= RST_CAL;
            cal_low_ff  <= RST_CAL;
        end else if (state_ff == CDR_TRACK && fall_edge && span_ok) begin
            cal_high_ff <= bt_next[15:FRAC_W];
            cal_low_ff  <= bt_next[FRAC_W-1:0];
        end
    end

    // Registered outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            miso_ff    <= 1'b0;
            miso_oe_ff <= 1'b0;
            bt_out_ff  <= '0;
            locked_ff  <= 1'b0;
        end else begin
            miso_ff    <= miso_int;
            miso_oe_ff <= miso_oe_int;
            bt_out_ff  <= cal_high_ff;
            locked_ff  <= state_ff == CDR_TRACK;
        end
    end

    assign spi_miso           = miso_ff;
    assign spi_miso_oe        = miso_oe_ff;
    assign recovered_bit_time = bt_out_ff;
    assign recovery_locked    = locked_ff;

endmodule : wake_frame_cdr_config

`default_nettype wire

// *** rtl/wake_cdr_pkg.sv ***
package wake_cdr_pkg;

    // Serial frame layout: address bits first, then mode bit, then data byte
    localparam int          ADDR_W         = 7;
    localparam int          DATA_W         = 8;
    localparam logic [4:0]  FRAME_BITS     = 5'h10;
    localparam logic [4:0]  HEADER_BITS    = 5'h08;
    localparam int          WRITE_BIT_POS  = 7;
    localparam int          DATA_LSB_POS   = 8;

    // Register addresses
    localparam logic [6:0]  OFS_CAL_HIGH   = 7'h3a;
    localparam logic [6:0]  OFS_CAL_LOW    = 7'h3b;
    localparam logic [6:0]  OFS_CTRL_ONE   = 7'h3c;
    localparam logic [6:0]  OFS_CLK_SEL    = 7'h3d;
    localparam logic [6:0]  OFS_UPPER_LIM  = 7'h3e;
    localparam logic [6:0]  OFS_LOWER_LIM  = 7'h3f;

    // Reset values
    localparam logic [7:0]  RST_CAL        = 8'h00;
    localparam logic [7:0]  RST_CTRL_ONE   = 8'h04;
    localparam logic [7:0]  RST_CLK_SEL    = 8'h00;
    localparam logic [7:0]  RST_UPPER_LIM  = 8'ha8;
    localparam logic [7:0]  RST_LOWER_LIM  = 8'h98;

    // Writable bits; everything else is reserved and reads zero
    localparam logic [7:0]  CTRL_ONE_MASK  = 8'h0d;
    localparam logic [7:0]  CLK_SEL_MASK   = 8'h03;
    localparam int          ENABLE_POS     = 0;
    localparam int          FILT_LSB       = 2;
    localparam int          FILT_MSB       = 3;
    localparam int          CLK_SEL_LSB    = 0;
    localparam int          CLK_SEL_MSB    = 1;

    // Edge filter codes and their time constants as shift amounts
    localparam logic [1:0]  FILT_TC8       = 2'h0;
    localparam logic [1:0]  FILT_TC16      = 2'h1;
    localparam logic [1:0]  FILT_TC32      = 2'h2;
    localparam logic [1:0]  FILT_ADAPT     = 2'h3;
    localparam logic [2:0]  SHIFT_TC8      = 3'h3;
    localparam logic [2:0]  SHIFT_TC16     = 3'h4;
    localparam logic [2:0]  SHIFT_TC32     = 3'h5;

    // Edge spacing bounds, in bit times
    localparam logic [3:0]  SPAN_MIN       = 4'h1;
    localparam logic [3:0]  ADAPT_TC32_MAX = 4'h3;
    localparam logic [3:0]  ADAPT_TC16_MAX = 4'h8;
    localparam logic [3:0]  SPAN_MAX       = 4'ha;
    localparam int          SPAN_SEARCH    = 11;

    // Recovery clock selection codes and tick periods in system clocks
    localparam logic [1:0]  CLK_80M        = 2'h0;
    localparam logic [1:0]  CLK_40M        = 2'h1;
    localparam logic [1:0]  CLK_20M        = 2'h2;
    localparam logic [3:0]  TICK_DIV_80M   = 4'h1;
    localparam logic [3:0]  TICK_DIV_40M   = 4'h2;
    localparam logic [3:0]  TICK_DIV_20M   = 4'h4;
    localparam logic [3:0]  TICK_DIV_10M   = 4'h8;

    // Bit time estimate: 8 integer bits and 8 fraction bits
    localparam int          FRAC_W         = 8;
    localparam int          INTERVAL_W     = 12;
    localparam logic [11:0] INTERVAL_MAX   = 12'hfff;

    typedef enum {CDR_OFF, CDR_SEEK, CDR_TRACK} cdr_state_e;

endpackage : wake_cdr_pkg

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Pins in, synchronised copies out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // Two stages; only the second stage is visible outside
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_ff <= INIT;
            sync_ff <= INIT;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule : pin_sync

`default_nettype wire

// *** rtl/serial_frame_slave.sv ***
`timescale 1ns/1ps
`default_nettype none

module serial_frame_slave
    import wake_cdr_pkg::*;
(
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         reset,
    // Synchronised serial pins
    input  wire logic                         sck,
    input  wire logic                         cs_n,
    input  wire logic                         mosi,
    // Read data for the addressed register
    input  wire logic [wake_cdr_pkg::DATA_W-1:0] rd_data,
    // Decoded frame
    output logic      [wake_cdr_pkg::ADDR_W-1:0] addr,
    output logic                              write_req,
    output logic      [wake_cdr_pkg::DATA_W-1:0] wr_data,
    output logic                              frame_done,
    // Serial data out
    output logic                              miso,
    output logic                              miso_oe
);
    import wake_cdr_pkg::*;

    logic        sck_d_ff;
    logic        cs_n_d_ff;
    logic [15:0] rx_ff;
    logic [4:0]  cnt_ff;
    logic [7:0]  tx_ff;
    logic        loaded_ff;
    logic        done_ff;
    logic        miso_ff;
    logic        miso_oe_ff;
    logic        sck_rise;
    logic        sck_fall;
    logic        cs_end;

    // Edge detection on the synchronised pins
    always_ff @(posedge clk) begin
        if (reset) begin
            sck_d_ff  <= 1'b0;
            cs_n_d_ff <= 1'b1;
        end else begin
            sck_d_ff  <= sck;
            cs_n_d_ff <= cs_n;
        end
    end

    assign sck_rise = sck & ~sck_d_ff & ~cs_n;
    assign sck_fall = ~sck & sck_d_ff & ~cs_n;
    assign cs_end   = cs_n & ~cs_n_d_ff;

    // Bit counter and receive register, LSB first, sampled on rising edges
    always_ff @(posedge clk) begin
        if (reset || cs_n) begin
            cnt_ff <= '0;
        end else if (sck_rise && cnt_ff != FRAME_BITS) begin
            cnt_ff       <= cnt_ff + 5'h01;
            rx_ff[cnt_ff[3:0]] <= mosi;
        end
    end

    // Register contents are captured once the address byte is complete
    always_ff @(posedge clk) begin
        if (reset || cs_n) begin
            loaded_ff <= 1'b0;
            tx_ff     <= '0;
            miso_ff   <= 1'b0;
        end else if (cnt_ff == HEADER_BITS && !loaded_ff) begin
            loaded_ff <= 1'b1;
            tx_ff     <= rd_data;
        end else if (sck_fall && loaded_ff) begin
            miso_ff <= tx_ff[0];
            tx_ff   <= {1'b0, tx_ff[7:1]};
        end
    end

    // Output driver enable and end-of-frame pulse; short frames are dropped
    always_ff @(posedge clk) begin
        if (reset) begin
            miso_oe_ff <= 1'b0;
            done_ff    <= 1'b0;
        end else begin
            miso_oe_ff <= ~cs_n;
            done_ff    <= cs_end && cnt_ff == FRAME_BITS;
        end
    end

    assign addr       = rx_ff[ADDR_W-1:0];
    assign write_req  = rx_ff[WRITE_BIT_POS];
    assign wr_data    = rx_ff[DATA_LSB_POS +: DATA_W];
    assign frame_done = done_ff;
    assign miso       = miso_ff;
    assign miso_oe    = miso_oe_ff;

endmodule : serial_frame_slave

`default_nettype wire

// *** sim/wake_cdr_host.sv ***
`timescale 1ns/1ps
`default_nettype none

module wake_cdr_host (
    // Clock
    input  wire logic clk,
    // Serial pins
    output logic      sck,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso,
    input  wire logic miso_oe
);
    // Clocks per sck half period, above the six-clock minimum
    localparam int HALF = 8;

    // Idle bus: select high, serial clock parked low
    initial begin
        sck  = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // One 16-bit frame, all fields LSB first
    task automatic xfer(input logic [6:0] addr, input logic wr, input logic [7:0] wdat,
                        output logic [7:0] rdat);
        logic [15:0] frame;
        frame = {wdat, wr, addr};
        rdat  = 8'h00;
        @(negedge clk);
        cs_n = 1'b0;
        for (int i = 0; i < 16; i++) begin
            mosi = frame[i];
            repeat (HALF) @(negedge clk);
            // Undriven line reads as unknown so a silent device cannot match
            if (i >= 8) rdat[i-8] = miso_oe ? miso : 1'bx;
            sck = 1'b1;
            repeat (HALF) @(negedge clk);
            sck = 1'b0;
        end
        repeat (HALF) @(negedge clk);
        cs_n = 1'b1;
        mosi = ~mosi;  // Released data line shows no stale bit
        repeat (HALF) @(negedge clk);
    endtask : xfer
endmodule : wake_cdr_host

`default_nettype wire

// *** sim/wake_frame_cdr_config_sva.sv ***
`timescale 1ns/1ps
`default_nettype none

module wake_frame_cdr_config_sva (
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       soft_reset,
    // Serial register port
    input wire logic       spi_sck,
    input wire logic       spi_cs_n,
    input wire logic       spi_mosi,
    input wire logic       spi_miso,
    input wire logic       spi_miso_oe,
    // Recovery side
    input wire logic       can_rxd,
    input wire logic [7:0] nominal_bit_time,
    input wire logic [7:0] recovered_bit_time,
    input wire logic       recovery_locked
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    logic        rxd_q;
    logic        cs_q;
    logic        sck_q;
    logic [15:0] fall_age;
    logic [5:0]  evt_age;
    logic [4:0]  rise_cnt;

    // Age of the last bus falling edge
    always_ff @(posedge clk) begin
        rxd_q <= can_rxd;
        if (reset) fall_age <= 16'hffff;
        else if (rxd_q && !can_rxd) fall_age <= 16'h0000;
        else if (fall_age != 16'hffff) fall_age <= fall_age + 16'h0001;
    end

    // Age of the last event allowed to move the calibration bytes
    always_ff @(posedge clk) begin
        cs_q <= spi_cs_n;
        if (reset || soft_reset || (rxd_q && !can_rxd) || (!cs_q && spi_cs_n)) evt_age <= 6'h00;
        else if (evt_age != 6'h3f) evt_age <= evt_age + 6'h01;
    end

    // Serial clock rises seen in the current frame
    always_ff @(posedge clk) begin
        sck_q <= spi_sck;
        if (spi_cs_n) rise_cnt <= 5'h00;
        else if (!sck_q && spi_sck && rise_cnt != 5'h1f) rise_cnt <= rise_cnt + 5'h01;
    end

    sequence s_select;
        $fell(spi_cs_n);
    endsequence
    sequence s_deselected;
        spi_cs_n [*6];
    endsequence

    a_reset_outputs: assert property (disable iff (1'b0)
        $fell(reset) |-> !spi_miso_oe && recovered_bit_time == 8'h00 && !recovery_locked)
        else $error("outputs not cleared by reset");
    a_soft_unlocks: assert property (soft_reset |-> ##[1:4] !recovery_locked)
        else $error("soft reset left recovery locked");
    a_soft_clears_cal: assert property ($fell(soft_reset) |-> ##[0:3] recovered_bit_time == 8'h00)
        else $error("soft reset did not clear recovered bit time");
    a_calib_from_edge: assert property (!$stable(recovered_bit_time) |-> evt_age < 6'd20)
        else $error("recovered bit time moved without a cause");
    a_lock_needs_edge: assert property ($rose(recovery_locked) |-> fall_age < 16'd12)
        else $error("lock without a falling edge");
    a_lock_times_out: assert property (recovery_locked |-> fall_age < 16'd33000)
        else $error("lock held past the edge timeout");
    a_oe_follows_select: assert property (s_select |-> ##[1:8] spi_miso_oe)
        else $error("miso not driven after select");
    a_oe_drops_deselect: assert property (s_deselected |-> !spi_miso_oe)
        else $error("miso driven while deselected");
    a_header_reads_zero: assert property ($rose(spi_sck) && spi_miso_oe && rise_cnt >= 5'h03
        && rise_cnt <= 5'h07 |-> !spi_miso)
        else $error("miso not zero during header byte");
endmodule : wake_frame_cdr_config_sva

bind wake_frame_cdr_config wake_frame_cdr_config_sva wake_frame_cdr_config_sva_inst (
    .clk(clk), .reset(reset), .soft_reset(soft_reset), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .can_rxd(can_rxd), .nominal_bit_time(nominal_bit_time),
    .recovered_bit_time(recovered_bit_time), .recovery_locked(recovery_locked)
);

`default_nettype wire

// *** sim/wake_frame_cdr_config_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module wake_frame_cdr_config_tb_top;
    import wake_cdr_pkg::*;

    logic       clk              = 1'b0;
    logic       reset            = 1'b1;
    logic       soft_reset       = 1'b0;
    logic       can_rxd          = 1'b1;
    logic [7:0] nominal_bit_time = 8'h40;
    logic       spi_sck;
    logic       spi_cs_n;
    logic       spi_mosi;
    logic       spi_miso;
    logic       spi_miso_oe;
    logic [7:0] recovered_bit_time;
    logic       recovery_locked;
    logic [7:0] rd;
    int         errors  = 0;
    int         n_tests = 0;
    int         cycles  = 0;

    wake_frame_cdr_config wake_frame_cdr_config_inst (
        .clk(clk), .reset(reset), .soft_reset(soft_reset),
        .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .can_rxd(can_rxd),
        .nominal_bit_time(nominal_bit_time), .recovered_bit_time(recovered_bit_time),
        .recovery_locked(recovery_locked)
    );
    wake_cdr_host wake_cdr_host_inst (
        .clk(clk), .sck(spi_sck), .cs_n(spi_cs_n), .mosi(spi_mosi),
        .miso(spi_miso), .miso_oe(spi_miso_oe)
    );

    // 50 MHz clock
    always #10 clk = ~clk;

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [6:0] addr, input logic [7:0] data);
        wake_cdr_host_inst.xfer(addr, 1'b1, data, rd);
    endtask : wr

    task automatic rdchk(input logic [6:0] addr, input logic [7:0] exp, input string what);
        wake_cdr_host_inst.xfer(addr, 1'b0, 8'h00, rd);
        check(what, exp, rd);
    endtask : rdchk

    task automatic fall_edge();
        can_rxd = 1'b0;
        repeat (4) @(negedge clk);
        can_rxd = 1'b1;
    endtask : fall_edge

    // Fresh start, two falling edges (n*64+d) ticks apart, then read the estimate
    task automatic run_case(input logic [1:0] sel, input logic [7:0] ctrl, input int n,
                            input int d, input logic [7:0] up, input logic [7:0] lo,
                            input logic [7:0] exp);
        int div;
        div              = 1 << sel;
        nominal_bit_time = 8'h40;
        soft_reset       = 1'b1;
        repeat (3) @(negedge clk);
        soft_reset = 1'b0;
        repeat (3) @(negedge clk);
        wr(OFS_UPPER_LIM, up);
        wr(OFS_LOWER_LIM, lo);
        wr(OFS_CLK_SEL, {6'h00, sel});
        wr(OFS_CTRL_ONE, ctrl);
        repeat (20) @(negedge clk);
        fall_edge();
        repeat ((n * 64 + d) * div - 4) @(negedge clk);
        fall_edge();
        repeat (20) @(negedge clk);
        check("locked", {7'h00, ctrl[ENABLE_POS]}, {7'h00, recovery_locked});
        check("recovered_bit_time", exp, recovered_bit_time);
        rdchk(OFS_CAL_HIGH, exp, "cal_high after edges");
    endtask : run_case

    // Main sequence
    initial begin
        repeat (10) @(negedge clk);
        reset = 1'b0;
        repeat (3) @(negedge clk);
        rdchk(OFS_CAL_HIGH, RST_CAL, "cal_high reset");
        rdchk(OFS_CAL_LOW, RST_CAL, "cal_low reset");
        rdchk(OFS_CTRL_ONE, RST_CTRL_ONE, "ctrl_one reset");
        rdchk(OFS_CLK_SEL, RST_CLK_SEL, "clk_sel reset");
        rdchk(OFS_UPPER_LIM, RST_UPPER_LIM, "upper_lim reset");
        rdchk(OFS_LOWER_LIM, RST_LOWER_LIM, "lower_lim reset");
        rdchk(7'h7f, 8'h00, "unmapped reset");
        $display("Test reset_values done");
        wr(OFS_CAL_HIGH, 8'hff);
        wr(OFS_CAL_LOW, 8'hff);
        wr(7'h7f, 8'h5a);
        rdchk(OFS_CAL_HIGH, 8'h00, "cal_high read only");
        rdchk(OFS_CAL_LOW, 8'h00, "cal_low read only");
        rdchk(7'h7f, 8'h00, "unmapped after write");
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CTRL_ONE, 8'hf2 | 8'(i << 2));
            rdchk(OFS_CTRL_ONE, 8'(i << 2), "ctrl_one masked");
            wr(OFS_CLK_SEL, 8'hfc | 8'(i));
            rdchk(OFS_CLK_SEL, 8'(i), "clk_sel masked");
        end
        $display("Test access_kinds done");
        nominal_bit_time = 8'h50;
        wr(OFS_CLK_SEL, 8'h01);
        wr(OFS_UPPER_LIM, 8'h54);
        wr(OFS_LOWER_LIM, 8'h4c);
        rdchk(OFS_UPPER_LIM, 8'h54, "upper_lim recommended");
        rdchk(OFS_LOWER_LIM, 8'h4c, "lower_lim recommended");
        $display("Test recommended_limits done");
        run_case(2'h0, 8'h01, 1, 20, 8'hff, 8'h00, 8'h42);
        run_case(2'h0, 8'h05, 1, 20, 8'hff, 8'h00, 8'h41);
        run_case(2'h0, 8'h09, 1, 20, 8'hff, 8'h00, 8'h40);
        run_case(2'h0, 8'h0d, 2, 20, 8'hff, 8'h00, 8'h40);
        run_case(2'h0, 8'h0d, 3, 20, 8'hff, 8'h00, 8'h40);
        run_case(2'h0, 8'h0d, 4, 20, 8'hff, 8'h00, 8'h41);
        run_case(2'h0, 8'h0d, 8, 20, 8'hff, 8'h00, 8'h41);
        run_case(2'h0, 8'h0d, 9, 20, 8'hff, 8'h00, 8'h42);
        run_case(2'h0, 8'h0d, 10, 20, 8'hff, 8'h00, 8'h42);
        run_case(2'h1, 8'h01, 1, 20, 8'hff, 8'h00, 8'h42);
        run_case(2'h2, 8'h01, 1, 20, 8'hff, 8'h00, 8'h42);
        run_case(2'h3, 8'h01, 1, 20, 8'hff, 8'h00, 8'h42);
        run_case(2'h0, 8'h01, 1, 26, 8'h41, 8'h00, 8'h41);
        run_case(2'h0, 8'h01, 1, -24, 8'hff, 8'h3f, 8'h3f);
        run_case(2'h0, 8'h00, 1, 20, 8'hff, 8'h00, 8'h00);
        rdchk(OFS_CTRL_ONE, 8'h00, "ctrl_one disabled");
        $display("Test recovery done");
        final_report();
    end
endmodule : wake_frame_cdr_config_tb_top

`default_nettype wire
